// ---- design/rtccal_pkg.sv ----
package rtccal_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_TIME_NOW = 8'h00;
    localparam logic [7:0] OFF_CAL_COMPARE = 8'h04;
    localparam logic [7:0] OFF_CAL_LOAD = 8'h08;
    localparam logic [7:0] OFF_YEAR_NOW = 8'h0C;
    localparam logic [7:0] OFF_YEAR_COMPARE = 8'h10;
    localparam logic [7:0] OFF_YEAR_LOAD = 8'h14;
    localparam logic [7:0] OFF_CONTROL = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
    localparam int SEC_LSB = 0;
    localparam int MIN_LSB = 6;
    localparam int HOUR_LSB = 12;
    localparam int WDAY_LSB = 17;
    localparam int MDAY_LSB = 20;
    localparam int MON_LSB = 25;
    localparam int YEAR_W = 14;
    localparam int RUN_BIT = 26;
    localparam int IRQ_W = 2;
    localparam int IRQ_MATCH_BIT = 0;
    localparam int IRQ_TICK_BIT = 1;
    localparam int SYNC_STAGES = 2;
    localparam logic [28:0] CAL_LOAD_RESET = 29'h0000000;
    localparam logic [28:0] CAL_COMPARE_RESET = 29'h0000000;
    localparam logic [13:0] YEAR_NOW_RESET = 14'h2000;
    localparam logic [13:0] YEAR_COMPARE_RESET = 14'h2000;
    localparam logic [13:0] YEAR_LOAD_RESET = 14'h0000;
    localparam logic [5:0] SEC_RESET = 6'h00;
    localparam logic [5:0] MIN_RESET = 6'h00;
    localparam logic [4:0] HOUR_RESET = 5'h00;
    localparam logic [2:0] WDAY_RESET = 3'h1;
    localparam logic [4:0] MDAY_RESET = 5'h01;
    localparam logic [3:0] MON_RESET = 4'h1;
    localparam logic [5:0] SEC_MAX = 6'h3B;
    localparam logic [5:0] MIN_MAX = 6'h3B;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [2:0] WDAY_MAX = 3'h7;
    localparam logic [3:0] MON_MAX = 4'hC;
    localparam logic [3:0] MON_FEB = 4'h2;
endpackage : rtccal_pkg

// ---- design/rtccal_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtccal_sync #(
    parameter int STAGES = 2
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic async_in,
    output logic rise_pulse
);
    if (STAGES < 2)
    begin : g_chk
        $error("rtccal_sync needs at least two stages");
    end

    logic [STAGES-1:0] sync_q;
    logic last_q;

    // Only the last stage is read, so a metastable first stage never reaches logic.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_q <= '0;
            last_q <= 1'b0;
        end
        else
        begin
            sync_q <= {sync_q[STAGES-2:0], async_in};
            last_q <= sync_q[STAGES-1];
        end
    end

    assign rise_pulse = sync_q[STAGES-1] & ~last_q;
endmodule : rtccal_sync
`default_nettype wire

// ---- design/rtccal_match.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtccal_match (
    input wire logic [28:0] compare,
    input wire logic [13:0] year_compare,
    input wire logic [5:0] sec,
    input wire logic [5:0] min,
    input wire logic [4:0] hour,
    input wire logic [2:0] wday,
    input wire logic [4:0] mday,
    input wire logic [3:0] mon,
    input wire logic [13:0] year,
    output logic hit
);
    logic [5:0] c_sec;
    logic [5:0] c_min;
    logic [4:0] c_hour;
    logic [2:0] c_wday;
    logic [4:0] c_mday;
    logic [3:0] c_mon;
    logic ok_time;
    logic ok_wday;
    logic ok_mday;
    logic ok_mon;

    assign c_sec = compare[rtccal_pkg::SEC_LSB +: 6];
    assign c_min = compare[rtccal_pkg::MIN_LSB +: 6];
    assign c_hour = compare[rtccal_pkg::HOUR_LSB +: 5];
    assign c_wday = compare[rtccal_pkg::WDAY_LSB +: 3];
    assign c_mday = compare[rtccal_pkg::MDAY_LSB +: 5];
    assign c_mon = compare[rtccal_pkg::MON_LSB +: 4];

    // Out-of-range time values can never equal a legal count, so they match only a count loaded with the same out-of-range value.
    assign ok_time = (c_sec == sec) && (c_min == min) && (c_hour == hour);
    assign ok_wday = (c_wday == 3'h0) || (c_wday == wday);
    assign ok_mday = (c_mday == 5'h00) || (c_mday == mday);
    // Zero ignores the month, 1 to 12 must equal it, 13 to 15 never match.
    assign ok_mon = (c_mon == 4'h0) || ((c_mon <= rtccal_pkg::MON_MAX) && (c_mon == mon));
    assign hit = ok_time && ok_wday && ok_mday && ok_mon && (year_compare == year);
endmodule : rtccal_match
`default_nettype wire

// ---- design/rtccal_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtccal_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick_1hz,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rtccal_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic calendar_match,
    output logic irq
);
    if (rtccal_pkg::ADDR_W < 6)
    begin : g_chk
        $error("rtccal_top needs an address of at least six bits");
    end

    if (rtccal_pkg::YEAR_W != 14)
    begin : g_year_chk
        $error("rtccal_top holds the year in exactly fourteen bits");
    end

    logic [28:0] cal_compare_q;
    logic [28:0] cal_load_q;
    logic [13:0] year_compare_q;
    logic [13:0] year_load_q;
    logic run_q;
    logic [rtccal_pkg::IRQ_W-1:0] irq_mask_q;
    logic [rtccal_pkg::IRQ_W-1:0] irq_status_q;
    logic [5:0] sec_q;
    logic [5:0] min_q;
    logic [4:0] hour_q;
    logic [2:0] wday_q;
    logic [4:0] mday_q;
    logic [3:0] mon_q;
    logic [13:0] year_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic match_q;
    logic irq_q;
    logic tick_pulse;
    logic step;
    logic start;
    logic hit;
    logic wr;
    logic [31:0] rd_d;
    logic err_d;
    logic ack;
    logic clr_status;

    function automatic logic [13:0] bcd_inc(input logic [13:0] y);
        logic [13:0] r;
        r = y;
        if (y[3:0] != 4'h9)
        begin
            r[3:0] = y[3:0] + 4'h1;
        end
        else
        begin
            r[3:0] = 4'h0;
            if (y[7:4] != 4'h9)
            begin
                r[7:4] = y[7:4] + 4'h1;
            end
            else
            begin
                r[7:4] = 4'h0;
                if (y[11:8] != 4'h9)
                begin
                    r[11:8] = y[11:8] + 4'h1;
                end
                else
                begin
                    r[11:8] = 4'h0;
                    r[13:12] = y[13:12] + 2'h1;
                end
            end
        end
        return r;
    endfunction : bcd_inc

    // Leap test uses the last two BCD digits only; century years are treated as leap.
    function automatic logic [4:0] month_len(input logic [3:0] m, input logic [13:0] y);
        logic leap;
        leap = y[4] ? ((y[3:0] == 4'h2) || (y[3:0] == 4'h6))
                    : ((y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8));
        case (m)
            rtccal_pkg::MON_FEB: month_len = leap ? 5'h1D : 5'h1C;
            4'h4, 4'h6, 4'h9, 4'hB: month_len = 5'h1E;
            default: month_len = 5'h1F;
        endcase
        return month_len;
    endfunction : month_len

    // The running count is set only through the load words, so a direct write is refused, not dropped silently.
    function automatic logic ro_addr(input logic [rtccal_pkg::ADDR_W-1:0] a);
        return (a == rtccal_pkg::OFF_YEAR_NOW) || (a == rtccal_pkg::OFF_TIME_NOW);
    endfunction : ro_addr

    rtccal_sync #(
        .STAGES(rtccal_pkg::SYNC_STAGES)
    ) u_tick (
        .clk(clk),
        .resetn(resetn),
        .async_in(tick_1hz),
        .rise_pulse(tick_pulse)
    );

    rtccal_match u_match (
        .compare(cal_compare_q),
        .year_compare(year_compare_q),
        .sec(sec_q),
        .min(min_q),
        .hour(hour_q),
        .wday(wday_q),
        .mday(mday_q),
        .mon(mon_q),
        .year(year_q),
        .hit(hit)
    );

    assign wr = psel && penable && pready_q && pwrite;
    assign start = wr && (paddr == rtccal_pkg::OFF_CONTROL) && !run_q && pwdata[rtccal_pkg::RUN_BIT];
    assign step = run_q && tick_pulse;
    assign ack = psel && penable && !pready_q;
    assign clr_status = wr && (paddr == rtccal_pkg::OFF_IRQ_STATUS);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cal_compare_q <= rtccal_pkg::CAL_COMPARE_RESET;
            cal_load_q <= rtccal_pkg::CAL_LOAD_RESET;
            year_compare_q <= rtccal_pkg::YEAR_COMPARE_RESET;
            year_load_q <= rtccal_pkg::YEAR_LOAD_RESET;
            irq_mask_q <= '0;
        end
        else if (wr)
        begin
            case (paddr)
                rtccal_pkg::OFF_CAL_COMPARE: cal_compare_q <= pwdata[28:0];
                // Load fields are stored as written; range checks are left to software.
                rtccal_pkg::OFF_CAL_LOAD: cal_load_q <= pwdata[28:0];
                rtccal_pkg::OFF_YEAR_COMPARE: year_compare_q <= pwdata[13:0];
                rtccal_pkg::OFF_YEAR_LOAD: year_load_q <= pwdata[13:0];
                rtccal_pkg::OFF_IRQ_MASK: irq_mask_q <= pwdata[rtccal_pkg::IRQ_W-1:0];
                default: irq_mask_q <= irq_mask_q;
            endcase
        end
    end

    // The enable is sticky: only a reset clears it, so a stray write cannot stop the clock.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            run_q <= 1'b0;
        end
        else if (start)
        begin
            run_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sec_q <= rtccal_pkg::SEC_RESET;
            min_q <= rtccal_pkg::MIN_RESET;
            hour_q <= rtccal_pkg::HOUR_RESET;
            wday_q <= rtccal_pkg::WDAY_RESET;
            mday_q <= rtccal_pkg::MDAY_RESET;
            mon_q <= rtccal_pkg::MON_RESET;
            year_q <= rtccal_pkg::YEAR_NOW_RESET;
        end
        else if (start)
        begin
            sec_q <= cal_load_q[rtccal_pkg::SEC_LSB +: 6];
            min_q <= cal_load_q[rtccal_pkg::MIN_LSB +: 6];
            hour_q <= cal_load_q[rtccal_pkg::HOUR_LSB +: 5];
            wday_q <= cal_load_q[rtccal_pkg::WDAY_LSB +: 3];
            mday_q <= cal_load_q[rtccal_pkg::MDAY_LSB +: 5];
            mon_q <= cal_load_q[rtccal_pkg::MON_LSB +: 4];
            year_q <= year_load_q;
        end
        else if (step)
        begin
            sec_q <= (sec_q >= rtccal_pkg::SEC_MAX) ? 6'h00 : sec_q + 6'h01;
            if (sec_q >= rtccal_pkg::SEC_MAX)
            begin
                min_q <= (min_q >= rtccal_pkg::MIN_MAX) ? 6'h00 : min_q + 6'h01;
                if (min_q >= rtccal_pkg::MIN_MAX)
                begin
                    hour_q <= (hour_q >= rtccal_pkg::HOUR_MAX) ? 5'h00 : hour_q + 5'h01;
                    if (hour_q >= rtccal_pkg::HOUR_MAX)
                    begin
                        wday_q <= (wday_q >= rtccal_pkg::WDAY_MAX) ? 3'h1 : wday_q + 3'h1;
                        if (mday_q >= month_len(mon_q, year_q))
                        begin
                            mday_q <= 5'h01;
                            mon_q <= (mon_q >= rtccal_pkg::MON_MAX) ? 4'h1 : mon_q + 4'h1;
                            if (mon_q >= rtccal_pkg::MON_MAX)
                            begin
                                year_q <= bcd_inc(year_q);
                            end
                        end
                        else
                        begin
                            mday_q <= mday_q + 5'h01;
                        end
                    end
                end
            end
        end
    end

    // The match is registered so that a new hit raises the event flag exactly once.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            match_q <= 1'b0;
        end
        else
        begin
            match_q <= hit && run_q;
        end
    end

    // A hardware event in the cycle of a write-one-to-clear keeps its bit set.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_status_q <= '0;
        end
        else
        begin
            for (int i = 0; i < rtccal_pkg::IRQ_W; i++)
            begin
                if ((i == rtccal_pkg::IRQ_MATCH_BIT) && hit && run_q && !match_q)
                begin
                    irq_status_q[i] <= 1'b1;
                end
                else if ((i == rtccal_pkg::IRQ_TICK_BIT) && step)
                begin
                    irq_status_q[i] <= 1'b1;
                end
                else if (clr_status && pwdata[i])
                begin
                    irq_status_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    always_comb
    begin
        rd_d = 32'h00000000;
        err_d = 1'b0;
        case (paddr)
            rtccal_pkg::OFF_TIME_NOW: rd_d = {3'h0, mon_q, mday_q, wday_q, hour_q, min_q, sec_q};
            rtccal_pkg::OFF_CAL_COMPARE: rd_d = {3'h0, cal_compare_q};
            rtccal_pkg::OFF_CAL_LOAD: rd_d = {3'h0, cal_load_q};
            rtccal_pkg::OFF_YEAR_NOW: rd_d = {18'h00000, year_q};
            rtccal_pkg::OFF_YEAR_COMPARE: rd_d = {18'h00000, year_compare_q};
            rtccal_pkg::OFF_YEAR_LOAD: rd_d = {18'h00000, year_load_q};
            rtccal_pkg::OFF_CONTROL: rd_d[rtccal_pkg::RUN_BIT] = run_q;
            rtccal_pkg::OFF_IRQ_MASK: rd_d[rtccal_pkg::IRQ_W-1:0] = irq_mask_q;
            rtccal_pkg::OFF_IRQ_STATUS: rd_d[rtccal_pkg::IRQ_W-1:0] = irq_status_q;
            default: err_d = 1'b1;
        endcase
    end

    // One wait state keeps read data and the error answer straight from flip-flops.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= ack;
            if (ack)
            begin
                prdata_q <= pwrite ? 32'h00000000 : rd_d;
                // Writes to the read-only time and year counts are refused as well as unmapped addresses.
                pslverr_q <= err_d || (pwrite && ro_addr(paddr));
            end
            else
            begin
                prdata_q <= 32'h00000000;
                pslverr_q <= 1'b0;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign calendar_match = match_q;
    assign irq = irq_q;
endmodule : rtccal_top
`default_nettype wire

// ---- bench/rtccal_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtccal_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick_1hz,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rtccal_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic calendar_match,
    input wire logic irq
);
    logic done;
    logic mon_bad;
    logic run_q;
    logic [3:0] mon_cmp_q;
    assign done = psel && penable && pready;
    assign mon_bad = mon_cmp_q >= 4'hD;
    // Shadows of the run bit and month compare, taken from completed writes only.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            run_q <= 1'b0;
        else if (done && pwrite && paddr == rtccal_pkg::OFF_CONTROL && pwdata[rtccal_pkg::RUN_BIT])
            run_q <= 1'b1;
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            mon_cmp_q <= 4'h0;
        else if (done && pwrite && paddr == rtccal_pkg::OFF_CAL_COMPARE)
            mon_cmp_q <= pwdata[28:25];
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    chk_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("access phase did not take exactly one wait state");
    chk_year_width: assert property (done && !pwrite && paddr inside {8'h0C, 8'h10, 8'h14} |-> prdata[31:14] == 18'h00000)
        else $error("year register shows bits above 13");
    chk_year_ro: assert property (done && pwrite && paddr == rtccal_pkg::OFF_YEAR_NOW |-> pslverr)
        else $error("write to current year not refused");
    chk_cmp_reserved: assert property (done && !pwrite && paddr inside {8'h04, 8'h08} |-> prdata[31:29] == 3'h0)
        else $error("calendar register shows reserved bits");
    chk_month_invalid: assert property (mon_bad && $past(mon_bad) && $past(mon_bad, 2) |-> !calendar_match)
        else $error("match with invalid month compare");
    chk_run_lock: assert property (done && !pwrite && paddr == rtccal_pkg::OFF_CONTROL && run_q |-> prdata[26])
        else $error("run enable lost after being set");
    chk_match_idle: assert property (!run_q |-> !calendar_match)
        else $error("match while clock not running");
    chk_unmapped_addr: assert property (done && paddr > rtccal_pkg::OFF_IRQ_STATUS |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");
    cover property ($rose(calendar_match));
    cover property ($rose(irq));
    cover property (done && pslverr);
endmodule : rtccal_props
bind rtccal_top rtccal_props u_props (.clk(clk), .resetn(resetn), .tick_1hz(tick_1hz), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .calendar_match(calendar_match), .irq(irq));
`default_nettype wire

// ---- bench/test_rtc_calendar_load_match_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_rtc_calendar_load_match_regs;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic tick_1hz = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic calendar_match;
    logic irq;
    int error_cnt = 0;
    int checked = 0;
    int seed = 32'h64F1B248;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [31:0] t_word;
    logic [31:0] r;
    logic [7:0] ra[3] = '{8'h04, 8'h10, 8'h14};
    logic [31:0] rm[3] = '{32'h1FFFFFFF, 32'h00003FFF, 32'h00003FFF};
    always #4 clk = ~clk;
    rtccal_top dut (.clk(clk), .resetn(resetn), .tick_1hz(tick_1hz), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .calendar_match(calendar_match), .irq(irq));
    task check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    // The pin is read only after the wait, so the value judged is the one the last write produced.
    task chk1(input logic sel, input logic want);
        repeat (4) @(posedge clk);
        check({31'h0, (sel ? irq : calendar_match)}, {31'h0, want});
    endtask : chk1
    task pulse_tick(input int n);
        repeat (n)
        begin
            tick_1hz <= 1'b1;
            repeat (8) @(posedge clk);
            tick_1hz <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask : pulse_tick
    task tally_and_finish;
        $display("Mismatches %0d, comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // One APB transfer; the expected response is queued first and judged by the monitor.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err, input logic [31:0] want);
        exp_q.push_back({w, err, want});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer
    function logic [31:0] pack(input logic [5:0] s, input logic [5:0] mi, input logic [4:0] h, input logic [2:0] w,
        input logic [4:0] md, input logic [3:0] mo);
        return {3'h0, mo, md, w, h, mi, s};
    endfunction : pack
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(32'h00000001, 32'h00000000);
            else
            begin
                e = exp_q.pop_front();
                check({31'h0, pslverr}, {31'h0, e[32]});
                if (!e[33])
                    check(prdata, e[31:0]);
            end
        end
    end
    // The whole sequence needs well under two thousand cycles.
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        xfer(1'b0, 8'h00, 32'h0, 1'b0, pack(6'h00, 6'h00, 5'h00, 3'h1, 5'h01, 4'h1));
        xfer(1'b0, 8'h04, 32'h0, 1'b0, 32'h00000000);
        xfer(1'b0, 8'h08, 32'h0, 1'b0, 32'h00000000);
        xfer(1'b0, 8'h0C, 32'h0, 1'b0, 32'h00002000);
        xfer(1'b0, 8'h10, 32'h0, 1'b0, 32'h00002000);
        xfer(1'b0, 8'h14, 32'h0, 1'b0, 32'h00000000);
        for (int i = 0; i < 3; i++)
        begin
            r = $random(seed);
            xfer(1'b1, ra[i], r, 1'b0, 32'h0);
            xfer(1'b0, ra[i], 32'h0, 1'b0, r & rm[i]);
        end
        xfer(1'b1, 8'h0C, 32'h00001999, 1'b1, 32'h0);
        xfer(1'b0, 8'h0C, 32'h0, 1'b0, 32'h00002000);
        xfer(1'b1, 8'h00, 32'h00000005, 1'b1, 32'h0);
        xfer(1'b0, 8'h40, 32'h0, 1'b1, 32'h00000000);
        xfer(1'b1, 8'h3C, $random(seed), 1'b1, 32'h0);
        // Only legal calendar values are loaded, at the top of every field except the seconds, which start at ten.
        t_word = pack(6'h0A, 6'h3B, 5'h17, 3'h7, 5'h1F, 4'hC);
        xfer(1'b1, 8'h08, t_word, 1'b0, 32'h0);
        xfer(1'b0, 8'h08, 32'h0, 1'b0, t_word);
        xfer(1'b1, 8'h14, 32'h00002024, 1'b0, 32'h0);
        xfer(1'b1, 8'h18, 32'h04000000, 1'b0, 32'h0);
        xfer(1'b1, 8'h18, 32'h00000000, 1'b0, 32'h0);
        xfer(1'b0, 8'h18, 32'h0, 1'b0, 32'h04000000);
        xfer(1'b0, 8'h00, 32'h0, 1'b0, t_word);
        xfer(1'b0, 8'h0C, 32'h0, 1'b0, 32'h00002024);
        pulse_tick(1);
        xfer(1'b0, 8'h00, 32'h0, 1'b0, pack(6'h0B, 6'h3B, 5'h17, 3'h7, 5'h1F, 4'hC));
        xfer(1'b1, 8'h10, 32'h00002024, 1'b0, 32'h0);
        for (int m = 0; m < 16; m++)
        begin
            xfer(1'b1, 8'h04, pack(6'h0B, 6'h3B, 5'h17, 3'h0, 5'h00, m[3:0]), 1'b0, 32'h0);
            chk1(1'b0, m == 0 || m == 12);
        end
        xfer(1'b1, 8'h04, pack(6'h0B, 6'h3B, 5'h17, 3'h7, 5'h00, 4'h0), 1'b0, 32'h0);
        chk1(1'b0, 1'b1);
        xfer(1'b1, 8'h04, pack(6'h0B, 6'h3B, 5'h17, 3'h6, 5'h00, 4'h0), 1'b0, 32'h0);
        chk1(1'b0, 1'b0);
        xfer(1'b1, 8'h04, pack(6'h0B, 6'h3B, 5'h17, 3'h0, 5'h1F, 4'h0), 1'b0, 32'h0);
        chk1(1'b0, 1'b1);
        xfer(1'b1, 8'h04, pack(6'h0B, 6'h3B, 5'h17, 3'h0, 5'h1E, 4'h0), 1'b0, 32'h0);
        chk1(1'b0, 1'b0);
        xfer(1'b1, 8'h20, 32'h00000003, 1'b0, 32'h0);
        xfer(1'b1, 8'h1C, 32'h00000001, 1'b0, 32'h0);
        chk1(1'b1, 1'b0);
        xfer(1'b1, 8'h04, pack(6'h0B, 6'h3B, 5'h17, 3'h0, 5'h00, 4'h0), 1'b0, 32'h0);
        chk1(1'b1, 1'b1);
        xfer(1'b0, 8'h20, 32'h0, 1'b0, 32'h00000001);
        xfer(1'b1, 8'h1C, 32'h00000000, 1'b0, 32'h0);
        chk1(1'b1, 1'b0);
        xfer(1'b1, 8'h1C, 32'h00000001, 1'b0, 32'h0);
        chk1(1'b1, 1'b1);
        xfer(1'b1, 8'h20, 32'h00000001, 1'b0, 32'h0);
        chk1(1'b1, 1'b0);
        xfer(1'b1, 8'h10, 32'h00002025, 1'b0, 32'h0);
        chk1(1'b0, 1'b0);
        // Forty-nine more steps carry the last second of the year into Sunday, January 1st of the next year.
        pulse_tick(49);
        xfer(1'b0, 8'h00, 32'h0, 1'b0, pack(6'h00, 6'h00, 5'h00, 3'h1, 5'h01, 4'h1));
        xfer(1'b0, 8'h0C, 32'h0, 1'b0, 32'h00002025);
        tally_and_finish();
    end
endmodule : test_rtc_calendar_load_match_regs
`default_nettype wire
